// ===== common/qio_pkg.sv
/*
 * qio_pkg: constants, carrier types and quadrature states shared by the
 * encoder quadrature/index output generator and its step generator.
 * Assumes one 10 MHz system clock and an active-low asynchronous reset.
 */
package qio_pkg;

	// clock and edge timing
	localparam int unsigned CLK_PERIOD_NS     = 100;
	localparam int unsigned EDGE_SKEW_MAX_NS  = 100;
	// longest time rounds down, never below one cycle
	localparam int unsigned EDGE_SKEW_MAX_CYC =
		(EDGE_SKEW_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 : (EDGE_SKEW_MAX_NS / CLK_PERIOD_NS);
	localparam int unsigned QUAD_FREQ_MAX_HZ  = 10_000_000;

	// widths and limits
	localparam int unsigned PERIOD_W      = 24;
	localparam int unsigned INTERP_W      = 9;
	localparam int unsigned INCR_W        = 11;
	localparam logic [8:0]  INTERP_MIN    = 9'h001;
	localparam logic [8:0]  INTERP_MAX    = 9'h100;   // 256-fold
	localparam int unsigned EDGES_PER_PER = 4;        // four quarter steps per period

	// reset values
	localparam logic [23:0] PERIOD_RST    = 24'h000000; // zero period means standing still
	localparam logic [8:0]  INTERP_RST    = 9'h001;

	// quadrature phase, one-hot; order 00 -> 10 -> 11 -> 01 runs channel a ahead
	typedef enum logic [3:0] {
		QIO_Q00 = 4'h1,
		QIO_Q10 = 4'h2,
		QIO_Q11 = 4'h4,
		QIO_Q01 = 4'h8
	} qio_quad_t;

	// six output lines: each channel with its complement
	typedef struct packed {
		logic a;
		logic a_n;
		logic b;
		logic b_n;
		logic z;
		logic z_n;
	} qio_lines_t;

	localparam qio_lines_t LINES_RST = 6'h15; // a,b,z low; complements high

endpackage : qio_pkg

// ===== hdl/qio_step_gen.sv
/*
 * qio_step_gen: fractional rate generator. Emits incr quarter steps for
 * every period cycles, spread evenly, at most one per clock, without a divider.
 * Assumes period and incr are stable register outputs; period 0 = stop.
 */
`timescale 1ns/100ps
module qio_step_gen (
	input  wire logic                          clk,
	input  wire logic                          resetn,
	input  wire logic [qio_pkg::PERIOD_W-1:0]  period,
	input  wire logic [qio_pkg::INCR_W-1:0]    incr,
	output logic                               step_reg,
	output logic [qio_pkg::PERIOD_W-1:0]       acc_reg
);

	logic [qio_pkg::PERIOD_W:0] sum;
	logic [qio_pkg::PERIOD_W:0] rem;

	// running sum; a step is due whenever it passes one tooth period
	assign sum = {1'b0, acc_reg} + {{(qio_pkg::PERIOD_W + 1 - qio_pkg::INCR_W){1'b0}}, incr};
	assign rem = sum - {1'b0, period};

	// at most one step per clock: faster demand saturates rather than overflows
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			acc_reg  <= 24'h000000;
			step_reg <= 1'b0;
		end else if (period == qio_pkg::PERIOD_RST) begin
			acc_reg  <= 24'h000000;
			step_reg <= 1'b0;
		end else if (sum >= {1'b0, period}) begin
			step_reg <= 1'b1;
			// clamp keeps the accumulator bounded when incr exceeds period
			acc_reg  <= (rem >= {1'b0, period}) ? 24'h000000 : rem[qio_pkg::PERIOD_W-1:0];
		end else begin
			step_reg <= 1'b0;
			acc_reg  <= sum[qio_pkg::PERIOD_W-1:0];
		end
	end

endmodule : qio_step_gen

// ===== hdl/qio_out.sv
/*
 * qio_out: incremental encoder square-wave output generator. Measures the
 * gear tooth period, interpolates it into quadrature steps and drives a, b
 * and the once-per-revolution index, each with its complement.
 * Assumes tooth_pulse and index_tooth are one-cycle pulses synchronous to
 * clk from the sensing front end, and dir_fwd, interp are synchronous levels.
 */
// Function
// - drive a, b and index, each with its complement: six lines.
// - channel b lags or leads a by a quarter cycle, edges alternate.
// - pulse period equals tooth period divided by interpolation factor; the code saturates at one quarter step per clock, a four-clock period.
// - successive edges across both channels are a quarter period apart.
// - each high or low phase of a channel lasts half a period.
// - index pulse lasts one quarter of the quadrature period.
// - output frequency is teeth times interpolation times speed over sixty.
// - interpolation factor selectable up to 256-fold.
// - quadrature frequency never exceeds 10 MHz.
`timescale 1ns/100ps
module qio_out #(
	parameter int unsigned STALL_CYCLES = 1_000_000 // 100 ms without a tooth = standstill
) (
	input  wire logic                          clk,
	input  wire logic                          resetn,
	input  wire logic                          tooth_pulse,
	input  wire logic                          index_tooth,
	input  wire logic                          dir_fwd,
	input  wire logic [qio_pkg::INTERP_W-1:0]  interp,
	output qio_pkg::qio_lines_t                lines_reg
);

	logic [qio_pkg::PERIOD_W-1:0] cnt_reg;
	logic [qio_pkg::PERIOD_W-1:0] period_reg;
	logic                         meas_run_reg;
	logic [qio_pkg::INTERP_W-1:0] interp_reg;
	logic [qio_pkg::INCR_W-1:0]   incr_reg;
	logic                         step;
	logic [qio_pkg::PERIOD_W-1:0] acc;
	qio_pkg::qio_quad_t           quad_reg;
	qio_pkg::qio_quad_t           quad_next;
	logic                         index_arm_reg;
	logic                         z_next;

	// clamp the interpolation factor to 1..256; a step count is four per period
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			interp_reg <= qio_pkg::INTERP_RST;
			incr_reg   <= 11'h004;
		end else begin
			if (interp < qio_pkg::INTERP_MIN) begin
				interp_reg <= qio_pkg::INTERP_MIN;
			end else if (interp > qio_pkg::INTERP_MAX) begin
				interp_reg <= qio_pkg::INTERP_MAX;
			end else begin
				interp_reg <= interp;
			end
			incr_reg <= {interp_reg, 2'b00};
		end
	end

	// tooth period in clocks; a long gap means the gear stands still
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_reg      <= 24'h000000;
			period_reg   <= qio_pkg::PERIOD_RST;
			meas_run_reg <= 1'b0;
		end else if (tooth_pulse) begin
			if (meas_run_reg) begin
				period_reg <= cnt_reg + 24'h000001;
			end
			meas_run_reg <= 1'b1;
			cnt_reg      <= 24'h000000;
		end else if (cnt_reg == 24'(STALL_CYCLES - 1)) begin
			// first tooth after standstill only restarts the measurement
			meas_run_reg <= 1'b0;
			period_reg   <= qio_pkg::PERIOD_RST;
			cnt_reg      <= 24'h000000;
		end else begin
			cnt_reg <= cnt_reg + 24'h000001;
		end
	end

	// even spread of 4*interp steps over each tooth period, at most one step per clock
	qio_step_gen u_step (
		.clk      (clk),
		.resetn   (resetn),
		.period   (period_reg),
		.incr     (incr_reg),
		.step_reg (step),
		.acc_reg  (acc)
	);

	// gray walk: one channel changes per step, direction picks the order
	always_comb begin
		quad_next = quad_reg;
		if (step) begin
			unique case (quad_reg)
				qio_pkg::QIO_Q00: quad_next = dir_fwd ? qio_pkg::QIO_Q10 : qio_pkg::QIO_Q01;
				qio_pkg::QIO_Q10: quad_next = dir_fwd ? qio_pkg::QIO_Q11 : qio_pkg::QIO_Q00;
				qio_pkg::QIO_Q11: quad_next = dir_fwd ? qio_pkg::QIO_Q01 : qio_pkg::QIO_Q10;
				qio_pkg::QIO_Q01: quad_next = dir_fwd ? qio_pkg::QIO_Q00 : qio_pkg::QIO_Q11;
				default:          quad_next = qio_pkg::QIO_Q00; // recover from a bad code
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			quad_reg <= qio_pkg::QIO_Q00;
		end else begin
			quad_reg <= quad_next;
		end
	end

	// index: armed by the index tooth, shown for the one quarter with a and b high,
	// so both its edges coincide with a quadrature edge
	assign z_next = step ? (quad_next == qio_pkg::QIO_Q11) && index_arm_reg : lines_reg.z;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			index_arm_reg <= 1'b0;
		end else if (index_tooth) begin
			index_arm_reg <= 1'b1;   // a new index wins over the clear below
		end else if (step && quad_next == qio_pkg::QIO_Q11) begin
			index_arm_reg <= 1'b0;
		end
	end

	// all six lines from one register so complements never skew
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			lines_reg <= qio_pkg::LINES_RST;
		end else begin
			lines_reg.a   <= quad_next[1] | quad_next[2];
			lines_reg.a_n <= ~(quad_next[1] | quad_next[2]);
			lines_reg.b   <= quad_next[2] | quad_next[3];
			lines_reg.b_n <= ~(quad_next[2] | quad_next[3]);
			lines_reg.z   <= z_next;
			lines_reg.z_n <= ~z_next;
		end
	end

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	a_pair_complement: assert property (
		(lines_reg.a_n != lines_reg.a) && (lines_reg.b_n != lines_reg.b)
		&& (lines_reg.z_n != lines_reg.z))
		else $error("complement line equals its channel");
	a_edges_alternate: assert property (
		$changed(lines_reg.a) |-> !$changed(lines_reg.b))
		else $error("a and b changed in the same cycle");
	a_stop_no_step: assert property (
		(period_reg == qio_pkg::PERIOD_RST) |=> !step)
		else $error("step while standing still");
	a_period_capture: assert property (
		(tooth_pulse && meas_run_reg) |=> (period_reg == $past(cnt_reg) + 24'h000001))
		else $error("tooth period not captured");
	a_step_even: assert property (
		(period_reg != qio_pkg::PERIOD_RST && {13'h0000, incr_reg} <= period_reg)
		|=> (acc < period_reg) || $changed(period_reg))
		else $error("step accumulator out of range");
	a_fwd_lead: assert property (
		(step && dir_fwd && quad_reg == qio_pkg::QIO_Q00) |=> $rose(lines_reg.a) && !lines_reg.b)
		else $error("channel a did not lead forward");
	a_rev_lead: assert property (
		(step && !dir_fwd && quad_reg == qio_pkg::QIO_Q00) |=> $rose(lines_reg.b) && !lines_reg.a)
		else $error("channel b did not lead reverse");
	a_index_quarter: assert property (
		$rose(lines_reg.z) |-> lines_reg.a && lines_reg.b
		&& ($rose(lines_reg.a) || $rose(lines_reg.b)))
		else $error("index not on the a-and-b-high quarter");
	a_index_skew: assert property (
		$fell(lines_reg.z) |-> ($changed(lines_reg.a) || $changed(lines_reg.b)))
		else $error("index fell away from a quadrature edge");
	a_rate_limit: assert property (
		$changed(lines_reg.a) |=> !$changed(lines_reg.a))
		else $error("channel a toggled on consecutive clocks");
	a_interp_range: assert property (
		(interp_reg >= qio_pkg::INTERP_MIN) && (interp_reg <= qio_pkg::INTERP_MAX))
		else $error("interpolation factor out of range");

	c_forward_run: cover property ((step && dir_fwd) ##[1:1000] (step && dir_fwd));
	c_reverse_run: cover property (step && !dir_fwd);
	c_index_pulse: cover property ($rose(lines_reg.z) ##[1:1000] $fell(lines_reg.z));
	c_standstill:  cover property ($fell(meas_run_reg));

endmodule : qio_out

// ===== bench/qio_rx_model.sv
/*
 * qio_rx_model: receiving counter on the far side of the encoder lines.
 * Assumes lines settle at rising clk edges; clr holds off gap statistics.
 */
`timescale 1ns/100ps
module qio_rx_model (
	input  wire logic          clk,
	input  wire logic          resetn,
	input  wire logic          clr,
	input  qio_pkg::qio_lines_t lines,
	output int                 pos,
	output int                 revs,
	output int                 gmin,
	output int                 gmax,
	output int                 zw,
	output logic               bad
);
	qio_pkg::qio_lines_t prev;
	int                  gap;
	int                  zc;
	logic                qe;

	// decode position, revolutions and timing; wire faults latch bad
	always @(posedge clk or negedge resetn) begin
		qe = (lines.a != prev.a) || (lines.b != prev.b);
		if (!resetn) begin
			prev <= qio_pkg::LINES_RST;
			{pos, revs, gap, zc, zw, gmax} <= '0;
			gmin <= 999;
			bad <= 1'b0;
		end else begin
			prev <= lines;
			gap <= gap + 1;
			zc <= zc + 1;
			if (clr) begin
				gmin <= 999;
				gmax <= 0;
				bad <= 1'b0;
			end
			if ({lines.a ^ lines.a_n, lines.b ^ lines.b_n, lines.z ^ lines.z_n} !== 3'h7)
				bad <= 1'b1;
			if (lines.a != prev.a && lines.b != prev.b)
				bad <= 1'b1;
			if (qe) begin
				gap <= 1;
				// a leading counts up, b leading counts down
				pos <= pos + ((lines.a ^ prev.b) ? 1 : -1);
				if (!clr && gap < gmin) gmin <= gap;
				if (!clr && gap > gmax) gmax <= gap;
			end
			if (lines.z != prev.z) begin
				if (!qe) bad <= 1'b1;
				if (lines.z) revs <= revs + 1;
				if (lines.z) zc <= 1;
				else zw <= zc;
			end
		end
	end
endmodule : qio_rx_model

// ===== bench/qio_out_tb.sv
/*
 * qio_out_tb: self-checking bench for qio_out with a receiving counter.
 * Assumes a 10 MHz clk; standstill timeout shortened to 200 cycles.
 */
`timescale 1ns/100ps
module qio_out_tb;
	typedef struct {logic [8:0] i; logic d; int n;} qio_row_t;
	logic                clk = 1'b0;
	logic                resetn = 1'b0;
	logic                tooth_pulse = 1'b0;
	logic                index_tooth = 1'b0;
	logic                dir_fwd = 1'b1;
	logic [8:0]          interp = 9'h001;
	logic                clr = 1'b1;
	qio_pkg::qio_lines_t lines_reg;
	qio_pkg::qio_lines_t hold;
	int                  pos, revs, gmin, gmax, zw, p0, r0, dl, sp;
	logic                bad;
	int                  n_mismatch = 0;
	int                  checked = 0;
	// interp 0 clamps to one-fold
	qio_row_t rows[5] = '{'{9'h001, 1'b1, 1}, '{9'h002, 1'b0, 2}, '{9'h004, 1'b1, 4},
		'{9'h003, 1'b0, 3}, '{9'h000, 1'b1, 1}};

	qio_out #(.STALL_CYCLES(200)) u_qio_out (.clk(clk), .resetn(resetn),
		.tooth_pulse(tooth_pulse), .index_tooth(index_tooth), .dir_fwd(dir_fwd),
		.interp(interp), .lines_reg(lines_reg));
	qio_rx_model u_qio_rx_model (.clk(clk), .resetn(resetn), .clr(clr),
		.lines(lines_reg), .pos(pos), .revs(revs), .gmin(gmin), .gmax(gmax),
		.zw(zw), .bad(bad));

	// 100 ns clock
	always #50 clk = ~clk;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
			n_mismatch++;
		end
	endtask : check

	task automatic finish_test;
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : finish_test

	// one tooth every s cycles, period counted from pulse to pulse
	task automatic tooth(input int s);
		@(posedge clk) tooth_pulse <= 1'b1;
		@(posedge clk) tooth_pulse <= 1'b0;
		repeat (s - 2) @(posedge clk);
	endtask : tooth

	// a hang costs far more than the ~3500 cycles the tests need
	initial begin
		#2_000_000;
		n_mismatch++;
		finish_test;
	end

	// main sequence
	initial begin
		repeat (2) @(posedge clk);
		check(lines_reg, qio_pkg::LINES_RST);
		resetn <= 1'b1;
		@(posedge clk);
		#1 check(lines_reg, qio_pkg::LINES_RST);
		foreach (rows[k]) begin
			// row inputs change only on a clock edge
			@(posedge clk);
			sp = 40 * rows[k].n; // ten clocks per quarter step
			clr <= 1'b1;
			interp <= rows[k].i;
			dir_fwd <= rows[k].d;
			repeat (3) tooth(sp);
			clr <= 1'b0;
			#1 p0 = pos;
			repeat (3) tooth(sp);
			#1 dl = (pos - p0) * (rows[k].d ? 1 : -1);
			check(dl >= 12 * rows[k].n - 2 && dl <= 12 * rows[k].n + 2, 1);
			check(gmin >= 8 && gmax <= 12, 1);
			check(bad, 1'b0);
			$display("rate test %0d done", k);
		end
		// repeated arm while armed gives one index pulse
		r0 = revs;
		@(posedge clk) index_tooth <= 1'b1;
		@(posedge clk) index_tooth <= 1'b1;
		@(posedge clk) index_tooth <= 1'b0;
		repeat (3) tooth(40);
		check(revs, r0 + 1);
		check(zw >= 8 && zw <= 12, 1);
		check(bad, 1'b0);
		// a second index in reverse rises together with a instead of b
		@(posedge clk) index_tooth <= 1'b1;
		dir_fwd <= 1'b0;
		@(posedge clk) index_tooth <= 1'b0;
		repeat (3) tooth(40);
		check(revs, r0 + 2);
		check(zw >= 8 && zw <= 12, 1);
		check(bad, 1'b0);
		$display("index test done");
		// factor above the limit clamps; demand beyond one step per clock saturates
		interp <= 9'h1FF;
		clr <= 1'b1;
		repeat (2) tooth(40);
		clr <= 1'b0;
		#1 p0 = pos;
		repeat (2) tooth(40);
		#1 check(p0 - pos, 80);
		check(gmin, 1);
		check(bad, 1'b0);
		$display("saturation test done");
		// no teeth: period drops to zero and the lines freeze
		repeat (300) @(posedge clk);
		#1 hold = lines_reg;
		repeat (50) @(posedge clk);
		#1 check(lines_reg, hold);
		$display("standstill test done");
		// reset in mid-run
		repeat (2) tooth(40);
		@(posedge clk) resetn <= 1'b0;
		repeat (2) @(posedge clk);
		#1 check(lines_reg, qio_pkg::LINES_RST);
		// after release the first tooth only restarts the measurement
		@(posedge clk) resetn <= 1'b1;
		tooth(40);
		#1 check(lines_reg, qio_pkg::LINES_RST);
		$display("reset test done");
		finish_test;
	end
endmodule : qio_out_tb
